// File: logic/dc_offset_pkg.sv
// constants for the offset measurement and slicer control block
package dc_offset_pkg;
    // ****************************************
    // register map (address = register number, except decoder register 7 at address 1)
    // ****************************************
    localparam logic [3:0] ADDR_LOOP_BW = 4'h8;
    localparam logic [3:0] ADDR_LOOP_EQ = 4'h9;
    localparam logic [3:0] ADDR_DIODE_SEL = 4'h3;
    localparam logic [3:0] ADDR_CANCEL = 4'h7;
    localparam logic [3:0] ADDR_BANKC = 4'hC;
    localparam logic [3:0] ADDR_DEC7 = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'hA;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hB;
    localparam logic [3:0] ADDR_BANK = 4'hD;
    localparam logic [3:0] ADDR_OFFSET = 4'hE;
    localparam logic [1:0] BANK_TWO = 2'h2;
    localparam logic [1:0] BANK_THREE = 2'h3;
    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [1:0] BANK_RST = 2'h3;
    localparam int SRC_LO = 1;
    localparam int CTRL_INV_BIT = 0;
    localparam int CTRL_PIN_OT_BIT = 1;
    localparam logic [1:0] DEC7_OFFSET_MODE = 2'h2;
    localparam logic [1:0] SRC_STATUS = 2'h0;
    localparam logic [1:0] SRC_READY = 2'h1;
    localparam logic [1:0] SRC_VALUE = 2'h2;
    localparam int CANCEL_WORDS = 9;
    // ****************************************
    // timing
    // ****************************************
    localparam longint CLK_HZ = 50000000;
    localparam longint SLICE_CLK_HZ = 67000000;
    localparam longint T0_NS = 354000;
    localparam longint T1_NS = 1000000;
    localparam longint T2_NS = 2000000;
    localparam longint T3_NS = 10000000;
    localparam longint T0_CYC = (T0_NS * CLK_HZ + 999999999) / 1000000000;
    localparam longint T1_CYC = (T1_NS * CLK_HZ + 999999999) / 1000000000;
    localparam longint T2_CYC = (T2_NS * CLK_HZ + 999999999) / 1000000000;
    localparam longint T3_CYC = (T3_NS * CLK_HZ + 999999999) / 1000000000;
    localparam int BAUD = 115200;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
endpackage

// File: logic/dc_offset_measure_and_slicer_ctrl.sv
// offset measurement, status pin mux, offset stream and slicer control
//
// Contract
// R1 - slicer logic clocked at 67 MHz; here clocked by the 50 MHz clk
// R2 - DPLL switches slice current sources
// R3 - bit clock regenerated internally, never output
// R4 - registers 8 and 9 set loop
// R5 - servo off-track default, polarity invertible
// R6 - decoder register C selects pin source; here ctrl_r bit 1 (address 2) selects the pin as off-track source
// R7 - off-track high marks HF data bad
// R8 - measurement time from two bits
// R9 - diode select decoding from four bits
// R10 - host sets decoder register 7 to 10
// R11 - status pin source from two bits
// R12 - ready flag high after measure time
// R13 - new diode code restarts timer
// R14 - host sets time, diode, then waits
// R15 - offset streamed repeatedly as UART
// R16 - MSB sent inverted, host re-inverts
// R17 - cancel register takes nine nibbles
// R18 - status pin shared among sources
// R19 - stream rate and framing are parameters
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
module dc_offset_measure_and_slicer_ctrl #(
    parameter longint T0_CYCLES = dc_offset_pkg::T0_CYC,
    parameter longint T1_CYCLES = dc_offset_pkg::T1_CYC,
    parameter longint T2_CYCLES = dc_offset_pkg::T2_CYC,
    parameter longint T3_CYCLES = dc_offset_pkg::T3_CYC,
    parameter int BAUD = dc_offset_pkg::BAUD, // R19
    parameter int DATA_BITS = dc_offset_pkg::DATA_BITS,
    parameter int STOP_BITS = dc_offset_pkg::STOP_BITS
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic resetn, // async reset, active low
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wrData, // write data
    input wire logic wrEn, // write strobe
    input wire logic rdEn, // read strobe
    output logic [7:0] rdData, // read data, cycle after rdEn
    input wire logic [7:0] offsetSample, // measured offset from adc
    input wire logic servoOffTrack, // servo off-track level
    input wire logic versatileInputOne, // pin, async
    input wire logic decoderStatus, // decoder status level
    input wire logic servoIrq, // servo interrupt request
    input wire logic hfSymbolValid, // incoming HF symbol strobe
    input wire logic dpllUp, // DPLL phase early
    input wire logic dpllDown, // DPLL phase late
    output logic statusPin, // shared status output
    output logic hfSymbolBad, // symbol flagged incorrect
    output logic sliceSrcUp, // slice current source up on
    output logic sliceSrcDown, // slice current source down on
    output logic [3:0] loopBandwidth, // bit clock PLL bandwidth
    output logic [3:0] loopEqualize, // bit clock PLL equalization
    output logic [2:0] diodeSel, // binary index of diode
    output logic [35:0] cancelLevels, // nine cancel nibbles
    output logic irq // level interrupt
);
    // ****************************************
    // reset release
    // ****************************************
    logic rstSync1_r, rstn_r;
    // release through two flops so the whole block leaves reset in one edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstn_r <= rstSync1_r;
        end
    end

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic v1a_r, v1b_r, v1c_r, v1_r;
    // change accepted only when second and third stages agree
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            v1a_r <= 1'b0;
            v1b_r <= 1'b0;
            v1c_r <= 1'b0;
            v1_r <= 1'b0;
        end else begin
            v1a_r <= versatileInputOne;
            v1b_r <= v1a_r;
            v1c_r <= v1b_r;
            if (v1b_r == v1c_r) v1_r <= v1c_r;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [3:0] measTime_r, diodeCode_r, pinCtrl_r, dec7_r, bw_r, eq_r;
    logic [1:0] ctrl_r, bank_r, irqStat_r, irqMask_r;
    logic [3:0] cancel_r [dc_offset_pkg::CANCEL_WORDS];
    logic [3:0] cancelIdx_r;
    logic [7:0] offsetHold_r;
    logic readyFlag_r, readyRise;
    logic streamWrap;
    logic wrDiode;

    function automatic logic isWr(input logic [3:0] a, input logic [3:0] target);
        return wrEn && (a == target);
    endfunction

    assign wrDiode = isWr(addr, dc_offset_pkg::ADDR_DIODE_SEL) && bank_r == dc_offset_pkg::BANK_THREE;

    // plain configuration registers; C is banked between time and pin source
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            measTime_r <= dc_offset_pkg::RST_NIBBLE;
            diodeCode_r <= dc_offset_pkg::RST_NIBBLE;
            pinCtrl_r <= dc_offset_pkg::RST_NIBBLE;
            dec7_r <= dc_offset_pkg::RST_NIBBLE;
            bw_r <= dc_offset_pkg::RST_NIBBLE;
            eq_r <= dc_offset_pkg::RST_NIBBLE;
            ctrl_r <= 2'h0;
            bank_r <= dc_offset_pkg::BANK_RST;
            irqMask_r <= 2'h0;
        end else if (wrEn) begin
            case (addr)
                dc_offset_pkg::ADDR_BANKC: begin
                    if (bank_r == dc_offset_pkg::BANK_TWO) measTime_r <= wrData[3:0]; // R8
                    else pinCtrl_r <= wrData[3:0]; // R11
                end
                dc_offset_pkg::ADDR_DIODE_SEL: begin
                    if (bank_r == dc_offset_pkg::BANK_THREE) diodeCode_r <= wrData[3:0];
                end
                dc_offset_pkg::ADDR_DEC7: dec7_r <= wrData[3:0];
                dc_offset_pkg::ADDR_LOOP_BW: bw_r <= wrData[3:0]; // R4
                dc_offset_pkg::ADDR_LOOP_EQ: eq_r <= wrData[3:0]; // R4
                dc_offset_pkg::ADDR_CTRL: ctrl_r <= wrData[1:0];
                dc_offset_pkg::ADDR_BANK: bank_r <= wrData[1:0];
                dc_offset_pkg::ADDR_IRQ_MASK: irqMask_r <= wrData[1:0];
                default: ;
            endcase
        end
    end

    // multi-write cancel register: each write fills the next nibble, wraps after nine
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            cancelIdx_r <= 4'h0;
            for (int i = 0; i < dc_offset_pkg::CANCEL_WORDS; i++) cancel_r[i] <= dc_offset_pkg::RST_NIBBLE;
        end else if (isWr(addr, dc_offset_pkg::ADDR_CANCEL) && bank_r == dc_offset_pkg::BANK_THREE) begin
            cancel_r[cancelIdx_r] <= wrData[3:0]; // R17
            if (cancelIdx_r == 4'(dc_offset_pkg::CANCEL_WORDS - 1)) cancelIdx_r <= 4'h0;
            else cancelIdx_r <= cancelIdx_r + 4'h1;
        end
    end

    // ****************************************
    // measurement timer
    // ****************************************
    logic [31:0] measCnt_r;
    logic [31:0] measLimit;
    // selected settling time; only low two bits matter
    always_comb begin
        case (measTime_r[1:0]) // R8
            2'h0: measLimit = 32'(T0_CYCLES);
            2'h1: measLimit = 32'(T1_CYCLES);
            2'h2: measLimit = 32'(T2_CYCLES);
            default: measLimit = 32'(T3_CYCLES);
        endcase
    end

    // restart on any diode select write with a new code, then count up
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            measCnt_r <= 32'h0;
            readyFlag_r <= 1'b0;
            offsetHold_r <= 8'h00;
        end else if (wrDiode && wrData[3:0] != diodeCode_r) begin
            measCnt_r <= 32'h0; // R13
            readyFlag_r <= 1'b0;
        end else if (!readyFlag_r) begin
            if (measCnt_r + 32'h1 >= measLimit) begin
                readyFlag_r <= 1'b1; // R12
                offsetHold_r <= offsetSample;
            end
            measCnt_r <= measCnt_r + 32'h1;
        end
    end

    logic readyDly_r;
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) readyDly_r <= 1'b0;
        else readyDly_r <= readyFlag_r;
    end
    assign readyRise = readyFlag_r && !readyDly_r;

    // diode decode: 0 and 7 and unused codes fall back to main diode one
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) diodeSel <= 3'h0;
        else begin
            case (diodeCode_r) // R9
                4'h2: diodeSel <= 3'h1;
                4'h3: diodeSel <= 3'h2;
                4'h4: diodeSel <= 3'h3;
                4'h5: diodeSel <= 3'h4;
                4'h6: diodeSel <= 3'h5;
                default: diodeSel <= 3'h0;
            endcase
        end
    end

    // ****************************************
    // offset UART stream
    // ****************************************
    localparam int BIT_CYC = int'(dc_offset_pkg::CLK_HZ / BAUD);
    localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    logic [15:0] baudCnt_r;
    logic [4:0] bitIdx_r;
    logic [FRAME_BITS-1:0] frame_r;
    logic txBit;
    logic valueSel;
    assign valueSel = pinCtrl_r[2:1] == dc_offset_pkg::SRC_VALUE;
    assign txBit = frame_r[0];
    assign streamWrap = bitIdx_r == 5'(FRAME_BITS - 1) && baudCnt_r == 16'(BIT_CYC - 1);

    // free-running frames while selected; frame reloads with MSB inverted
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            baudCnt_r <= 16'h0;
            bitIdx_r <= 5'h0;
            frame_r <= '1;
        end else if (!valueSel) begin
            baudCnt_r <= 16'h0;
            bitIdx_r <= 5'h0;
            frame_r <= {{STOP_BITS{1'b1}}, ~offsetHold_r[7], offsetHold_r[6:0], 1'b0}; // R16
        end else if (baudCnt_r == 16'(BIT_CYC - 1)) begin
            baudCnt_r <= 16'h0;
            if (streamWrap) begin
                bitIdx_r <= 5'h0; // R15
                frame_r <= {{STOP_BITS{1'b1}}, ~offsetHold_r[7], offsetHold_r[6:0], 1'b0}; // R16
            end else begin
                bitIdx_r <= bitIdx_r + 5'h1;
                frame_r <= {1'b1, frame_r[FRAME_BITS-1:1]};
            end
        end else baudCnt_r <= baudCnt_r + 16'h1;
    end

    // ****************************************
    // off-track, slicer, status pin
    // ****************************************
    logic offTrack;
    assign offTrack = ctrl_r[dc_offset_pkg::CTRL_PIN_OT_BIT] ? v1_r // R6
                    : (servoOffTrack ^ ctrl_r[dc_offset_pkg::CTRL_INV_BIT]); // R5

    // registered outputs; slicer sources follow DPLL, bit clock stays inside
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            hfSymbolBad <= 1'b0;
            sliceSrcUp <= 1'b0;
            sliceSrcDown <= 1'b0;
            statusPin <= 1'b0;
        end else begin
            hfSymbolBad <= hfSymbolValid && offTrack; // R7
            sliceSrcUp <= dpllUp && !dpllDown; // R2; clocked by the 50 MHz clk, not the 67 MHz of R1
            sliceSrcDown <= dpllDown && !dpllUp; // R2
            if (dec7_r[1:0] != dc_offset_pkg::DEC7_OFFSET_MODE) statusPin <= servoIrq; // R18
            else begin
                case (pinCtrl_r[2:1]) // R11
                    dc_offset_pkg::SRC_READY: statusPin <= readyFlag_r;
                    dc_offset_pkg::SRC_VALUE: statusPin <= txBit; // R15
                    default: statusPin <= decoderStatus;
                endcase
            end
        end
    end

    // ****************************************
    // interrupts and readback
    // ****************************************
    // bit0 ready rose, bit1 stream frame done; set beats write-one clear
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) irqStat_r <= 2'h0;
        else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 && readyRise) || (i == 1 && streamWrap && valueSel)) irqStat_r[i] <= 1'b1;
                else if (isWr(addr, dc_offset_pkg::ADDR_IRQ_STAT) && wrData[i]) irqStat_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) irq <= 1'b0;
        else irq <= |(irqStat_r & irqMask_r);
    end

    // unmapped addresses read zero
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) rdData <= 8'h00;
        else if (rdEn) begin
            case (addr)
                dc_offset_pkg::ADDR_BANKC:
                    rdData <= {4'h0, bank_r == dc_offset_pkg::BANK_TWO ? measTime_r : pinCtrl_r};
                dc_offset_pkg::ADDR_DIODE_SEL: rdData <= {4'h0, diodeCode_r};
                dc_offset_pkg::ADDR_CANCEL: rdData <= {cancelIdx_r, 4'h0};
                dc_offset_pkg::ADDR_DEC7: rdData <= {4'h0, dec7_r};
                dc_offset_pkg::ADDR_LOOP_BW: rdData <= {4'h0, bw_r};
                dc_offset_pkg::ADDR_LOOP_EQ: rdData <= {4'h0, eq_r};
                dc_offset_pkg::ADDR_CTRL: rdData <= {6'h0, ctrl_r};
                dc_offset_pkg::ADDR_BANK: rdData <= {6'h0, bank_r};
                dc_offset_pkg::ADDR_IRQ_STAT: rdData <= {readyFlag_r, 5'h0, irqStat_r};
                dc_offset_pkg::ADDR_IRQ_MASK: rdData <= {6'h0, irqMask_r};
                dc_offset_pkg::ADDR_OFFSET: rdData <= offsetHold_r;
                default: rdData <= 8'h00;
            endcase
        end else rdData <= 8'h00;
    end

    // PLL settings and cancel words presented from flops
    always_ff @(posedge clk or negedge rstn_r) begin
        if (!rstn_r) begin
            loopBandwidth <= 4'h0;
            loopEqualize <= 4'h0;
            cancelLevels <= 36'h0;
        end else begin
            loopBandwidth <= bw_r; // R4
            loopEqualize <= eq_r;
            for (int i = 0; i < dc_offset_pkg::CANCEL_WORDS; i++) cancelLevels[i*4 +: 4] <= cancel_r[i];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_restart; // R13
        @(posedge clk) disable iff (!rstn_r) (wrDiode && wrData[3:0] != diodeCode_r) |=> !readyFlag_r && measCnt_r == 0;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");
    property p_ready; // R12
        @(posedge clk) disable iff (!rstn_r) $rose(readyFlag_r) |-> $past(measCnt_r) + 1 >= measLimit;
    endproperty
    a_ready: assert property (p_ready) else $error("ready too early");
    property p_badsym; // R7
        @(posedge clk) disable iff (!rstn_r) (hfSymbolValid && offTrack) |=> hfSymbolBad;
    endproperty
    a_badsym: assert property (p_badsym) else $error("symbol not flagged");
    property p_src; // R11
        @(posedge clk) disable iff (!rstn_r)
            (dec7_r[1:0] == 2'h2 && pinCtrl_r[2:1] == 2'h1) |=> statusPin == $past(readyFlag_r);
    endproperty
    a_src: assert property (p_src) else $error("status pin wrong source");
    property p_start; // R15
        @(posedge clk) disable iff (!rstn_r) (valueSel && bitIdx_r == 0) |-> frame_r[0] == 1'b0;
    endproperty
    a_start: assert property (p_start) else $error("missing start bit");
    property p_msb; // R16
        @(posedge clk) disable iff (!rstn_r) (valueSel && bitIdx_r == 0) |-> frame_r[DATA_BITS] == ~offsetHold_r[7];
    endproperty
    a_msb: assert property (p_msb) else $error("msb not inverted");
    property p_cancel; // R17
        @(posedge clk) disable iff (!rstn_r) cancelIdx_r < 4'(dc_offset_pkg::CANCEL_WORDS);
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel index overflow");
    property p_slice; // R2
        @(posedge clk) disable iff (!rstn_r) !(sliceSrcUp && sliceSrcDown);
    endproperty
    a_slice: assert property (p_slice) else $error("both sources on");
endmodule // dc_offset_measure_and_slicer_ctrl

// File: sim/host_uart_rx.sv
// host side receiver for the offset stream on the status pin
`timescale 1ns/1ns
module host_uart_rx #(
    parameter int BIT_CYC = 10 // clocks per serial bit
) (
    input wire logic clk, // system clock
    input wire logic line // status pin as seen by the host
);
    // ********
    // frame capture
    // ********
    // waits for idle high then a start edge; a bounded wait keeps a dead pin from hanging
    task automatic getByte(output logic [7:0] b, output logic ok);
        int i;
        int g;
        g = 0;
        b = 8'h00;
        while (line !== 1'b1 && g < 1000) begin
            @(negedge clk);
            g++;
        end
        while (line !== 1'b0 && g < 1000) begin
            @(negedge clk);
            g++;
        end
        repeat (BIT_CYC / 2) @(negedge clk);
        ok = (line === 1'b0) && (g < 1000);
        for (i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clk);
            b[i] = line;
        end
        repeat (BIT_CYC) @(negedge clk);
        ok = ok && (line === 1'b1);
        b[7] = ~b[7];
    endtask
endmodule // host_uart_rx

// File: sim/dc_offset_measure_and_slicer_ctrl_tb.sv
// register-level testbench for the offset measurement block
`timescale 1ns/1ns
module dc_offset_measure_and_slicer_ctrl_tb;
    localparam int LIM [4] = '{20, 30, 40, 50};
    localparam logic [2:0] DSEL [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
    // ctrl[4:3], servo, pin, expected bad flag
    localparam logic [4:0] OT [6] = '{5'h05, 5'h02, 5'h09, 5'h0C, 5'h13, 5'h14};
    logic clk, resetn, wrEn, rdEn, servoOffTrack, versatileInputOne, decoderStatus;
    logic servoIrq, hfSymbolValid, dpllUp, dpllDown, statusPin, hfSymbolBad, sliceSrcUp, sliceSrcDown, irq;
    logic [3:0] addr, loopBandwidth, loopEqualize;
    logic [7:0] wrData, rdData, offsetSample, rv;
    logic [2:0] diodeSel;
    logic [35:0] cancelLevels;
    logic ok;
    int fails = 0;
    int nChecks = 0;

    // short counts keep the run small; 10 clocks per bit
    // framing stays at its defaults; the host's default of 10 clocks per bit matches this rate
    dc_offset_measure_and_slicer_ctrl #(.T0_CYCLES(LIM[0]), .T1_CYCLES(LIM[1]), .T2_CYCLES(LIM[2]),
        .T3_CYCLES(LIM[3]), .BAUD(5000000)) dut (.clk(clk), .resetn(resetn), .addr(addr),
        .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .offsetSample(offsetSample),
        .servoOffTrack(servoOffTrack), .versatileInputOne(versatileInputOne), .decoderStatus(decoderStatus),
        .servoIrq(servoIrq), .hfSymbolValid(hfSymbolValid), .dpllUp(dpllUp), .dpllDown(dpllDown),
        .statusPin(statusPin), .hfSymbolBad(hfSymbolBad), .sliceSrcUp(sliceSrcUp), .sliceSrcDown(sliceSrcDown),
        .loopBandwidth(loopBandwidth), .loopEqualize(loopEqualize), .diodeSel(diodeSel),
        .cancelLevels(cancelLevels), .irq(irq));
    host_uart_rx host (.clk(clk), .line(statusPin));

    // ********
    // shared tasks
    // ********
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        @(negedge clk);
        d = rdData;
    endtask
    // a changed diode code restarts the timer; pin must drop then rise near the limit
    task automatic measure(input logic [3:0] code, input int lim);
        int c;
        wr(dc_offset_pkg::ADDR_DIODE_SEL, {4'h0, code});
        settle(2);
        check(statusPin, 1'b0);
        c = 0;
        while (statusPin !== 1'b1 && c < 2000) begin
            @(negedge clk);
            c++;
        end
        check(c >= lim - 3 && c <= lim + 3, 1'b1);
    endtask
    task automatic symbol(input logic exp);
        @(posedge clk) hfSymbolValid <= 1'b1;
        @(posedge clk) hfSymbolValid <= 1'b0;
        @(negedge clk);
        check(hfSymbolBad, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ********
    // watchdog
    // ********
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end

    // ********
    // main sequence
    // ********
    initial begin
        {resetn, wrEn, rdEn, servoOffTrack, versatileInputOne, decoderStatus} = 6'h00;
        {servoIrq, hfSymbolValid, dpllUp, dpllDown, addr, wrData, offsetSample} = 24'h000000;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(dc_offset_pkg::ADDR_DIODE_SEL, rv);
        check(rv, 8'h00);
        rd(dc_offset_pkg::ADDR_BANKC, rv);
        check(rv, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, rv);
        check(rv, 8'h00);
        wr(dc_offset_pkg::ADDR_LOOP_BW, 8'h05);
        wr(dc_offset_pkg::ADDR_LOOP_EQ, 8'h0A);
        settle(2);
        check({loopBandwidth, loopEqualize}, 8'h5A);
        rd(dc_offset_pkg::ADDR_LOOP_BW, rv);
        check(rv, 8'h05);
        @(posedge clk) dpllUp <= 1'b1;
        settle(3);
        check({sliceSrcUp, sliceSrcDown}, 2'b10);
        @(posedge clk) {dpllUp, dpllDown} <= 2'b01;
        settle(3);
        check({sliceSrcUp, sliceSrcDown}, 2'b01);
        @(posedge clk) servoIrq <= 1'b1;
        settle(3);
        check(statusPin, 1'b1);
        wr(dc_offset_pkg::ADDR_DEC7, 8'h02);
        @(posedge clk) decoderStatus <= 1'b1;
        settle(3);
        check(statusPin, 1'b1);
        @(posedge clk) decoderStatus <= 1'b0;
        settle(3);
        check(statusPin, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(dc_offset_pkg::ADDR_CTRL, {6'h00, OT[i][4:3]});
            @(posedge clk) {servoOffTrack, versatileInputOne} <= OT[i][2:1];
            settle(6);
            symbol(OT[i][0]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(dc_offset_pkg::ADDR_DIODE_SEL, 8'(i));
            settle(2);
            check(diodeSel, DSEL[i]);
        end
        for (int i = 0; i < 9; i++) wr(dc_offset_pkg::ADDR_CANCEL, 8'(i + 1));
        settle(2);
        check(cancelLevels, 36'h987654321);
        // host order: source to ready flag, interrupts disabled and cleared first; a mask bit high enables
        wr(dc_offset_pkg::ADDR_BANKC, 8'h02);
        wr(dc_offset_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(dc_offset_pkg::ADDR_IRQ_STAT, 8'hFF);
        @(posedge clk) offsetSample <= 8'h7F;
        for (int k = 0; k < 4; k++) begin
            wr(dc_offset_pkg::ADDR_BANK, 8'h02);
            wr(dc_offset_pkg::ADDR_BANKC, 8'(k));
            wr(dc_offset_pkg::ADDR_BANK, 8'h03);
            measure(4'(5 + k % 2), LIM[k]);
        end
        check(irq, 1'b0);
        rd(dc_offset_pkg::ADDR_IRQ_STAT, rv);
        check(rv & 8'h81, 8'h81);
        wr(dc_offset_pkg::ADDR_IRQ_MASK, 8'h01);
        settle(2);
        check(irq, 1'b1);
        wr(dc_offset_pkg::ADDR_IRQ_STAT, 8'h01);
        settle(2);
        check(irq, 1'b0);
        rd(dc_offset_pkg::ADDR_OFFSET, rv);
        check(rv, 8'h7F);
        wr(dc_offset_pkg::ADDR_BANKC, 8'h04);
        for (int j = 0; j < 2; j++) begin
            host.getByte(rv, ok);
            check({ok, rv}, {1'b1, 8'h7F});
        end
        rd(dc_offset_pkg::ADDR_IRQ_STAT, rv);
        check(rv & 8'h02, 8'h02);
        wr(dc_offset_pkg::ADDR_BANKC, 8'h02);
        @(posedge clk) offsetSample <= 8'h00;
        measure(4'h5, LIM[3]);
        wr(dc_offset_pkg::ADDR_BANKC, 8'h04);
        host.getByte(rv, ok);
        check({ok, rv}, {1'b1, 8'h00});
        report_and_stop();
    end
endmodule // dc_offset_measure_and_slicer_ctrl_tb
